// ===== pkg/adc_seq_map.svh
/*
  Register offsets, field positions, reset values and timing counts of the
  conversion sequencer.
  Assumes a 12-bit APB byte address and 32-bit data.
*/
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH

// ------------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------------
`define ADC_OFS_CONTROL 12'h000
`define ADC_OFS_PIN_CONFIG 12'h004
`define ADC_OFS_RESULT 12'h008
`define ADC_OFS_IRQ_STATUS 12'h00c
`define ADC_OFS_IRQ_MASK 12'h010
`define ADC_OFS_GLOBAL_IRQ 12'h014
`define ADC_OFS_PIN_DIR 12'h018

// ------------------------------------------------------------------------
// Field positions of converter_control_0
// ------------------------------------------------------------------------
`define ADC_CTL_ON 0
`define ADC_CTL_GO 2
`define ADC_CTL_CHS_LSB 3
`define ADC_CTL_CHS_MSB 5
`define ADC_CTL_CS_LSB 6
`define ADC_CTL_CS_MSB 7

// ------------------------------------------------------------------------
// Widths, bit positions and reset values
// ------------------------------------------------------------------------
`define ADC_RESULT_BITS 8
`define ADC_RESULT_MSB 3'h7
`define ADC_PIN_BITS 4
`define ADC_DONE_BIT 0
`define ADC_CTL_RESET 8'h00
`define ADC_PIN_CONFIG_RESET 4'h0
`define ADC_PIN_DIR_RESET 4'hf
`define ADC_SAR_START 8'h80

// ------------------------------------------------------------------------
// Clocks per bit_conversion_period for each conversion clock select
// ------------------------------------------------------------------------
`define ADC_TAD_DIV0 7'h02
`define ADC_TAD_DIV1 7'h08
`define ADC_TAD_DIV2 7'h20
`define ADC_TAD_DIV3 7'h40

`endif

// ===== pkg/adc_seq_pkg.sv
/*
  Types shared by the conversion sequencer files.
  Assumes nothing of its surroundings.
*/
package adc_seq_pkg;

  typedef enum logic [0:0] {
    seq_idle,
    seq_convert
  } seq_state_t;

  typedef logic [1:0] clock_select_t;

endpackage

// ===== verilog/bit_period_divider.sv
/*
  Divider that gives a one-cycle tick once every bit_conversion_period.
  Assumes div is at least 2 and stable while enable is high.
*/
`timescale 1ns/100ps
`include "adc_seq_map.svh"

module bit_period_divider
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic clear,
  input wire logic enable,
  input wire logic [6:0] div,
  // Tick
  output logic tick
);

  logic [6:0] count;
  logic [6:0] next_count;
  wire last = (count == div - 7'h01);

  assign next_count = (clear || !enable || last) ? 7'h00 : count + 7'h01;
  assign tick = enable && !clear && last;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count <= 7'h00;
    else
      count <= next_count;
  end

endmodule

// ===== verilog/adc_sequencer.sv
/*
  Successive-approximation conversion sequencer with an APB register file.
  Assumes an external DAC and comparator: cmp_high is high when the selected
  analog input is at or above dac_code, sampled synchronously to pclk.
*/
`timescale 1ns/100ps
`include "adc_seq_map.svh"


module adc_sequencer
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog front end
  input wire logic cmp_high,
  output logic [7:0] dac_code,
  output logic [2:0] channel_sel,
  output logic sample_hold,
  output logic converter_power,
  output logic [3:0] pin_config,
  output logic [3:0] pin_direction_bits,
  // Interrupt
  output logic irq
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  adc_seq_pkg::seq_state_t state;
  adc_seq_pkg::seq_state_t next_state;
  logic [7:0] control;
  logic [7:0] next_control;
  logic [3:0] next_pin_config;
  logic [3:0] next_pin_direction_bits;
  logic [7:0] conversion_result_reg;
  logic [7:0] sar;
  logic [7:0] next_sar;
  logic [2:0] bit_index;
  logic [2:0] next_bit_index;
  logic conversion_done_flag;
  logic next_done_flag;
  logic conversion_irq_enable;
  logic global_irq_enable;
  logic [31:0] next_prdata;
  logic [6:0] tad_div;
  logic tad_tick;

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  wire setup = psel && !penable;
  wire wr = psel && penable && pwrite;
  wire hit_control = (paddr == `ADC_OFS_CONTROL);
  wire hit_pin_config = (paddr == `ADC_OFS_PIN_CONFIG);
  wire hit_result = (paddr == `ADC_OFS_RESULT);
  wire hit_status = (paddr == `ADC_OFS_IRQ_STATUS);
  wire hit_mask = (paddr == `ADC_OFS_IRQ_MASK);
  wire hit_global = (paddr == `ADC_OFS_GLOBAL_IRQ);
  wire hit_pin_dir = (paddr == `ADC_OFS_PIN_DIR);
  wire mapped = hit_control || hit_pin_config || hit_result || hit_status
    || hit_mask || hit_global || hit_pin_dir;

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ----------------------------------------------------------------------
  // Conversion control
  // ----------------------------------------------------------------------
  wire conv_on = control[`ADC_CTL_ON];
  wire busy = (state == adc_seq_pkg::seq_convert);
  wire wr_control = wr && hit_control;
  wire go_write = wr_control && pwdata[`ADC_CTL_GO] && pwdata[`ADC_CTL_ON];
  wire start = go_write && !busy;
  wire last_bit = busy && tad_tick && (bit_index == 3'h0);
  wire finish = last_bit && conv_on;
  wire abort = busy && wr_control && !pwdata[`ADC_CTL_ON];
  wire adc_seq_pkg::clock_select_t clk_sel = control[`ADC_CTL_CS_MSB:`ADC_CTL_CS_LSB];
  wire [7:0] cmp_keep = sar & ~(8'h01 << bit_index);

  assign tad_div = (clk_sel == 2'h0) ? `ADC_TAD_DIV0 :
                   (clk_sel == 2'h1) ? `ADC_TAD_DIV1 :
                   (clk_sel == 2'h2) ? `ADC_TAD_DIV2 : `ADC_TAD_DIV3;

  bit_period_divider u_tad
  (
    .pclk(pclk),
    .presetn(presetn),
    .clear(start),
    .enable(busy),
    .div(tad_div),
    .tick(tad_tick)
  );

  // Control register: software owns every field but go, which only hardware
  // clears, and channel and clock select freeze while a conversion runs.
  always_comb
  begin
    next_control = control;
    if (wr_control)
    begin
      next_control[`ADC_CTL_ON] = pwdata[`ADC_CTL_ON];
      if (!busy)
      begin
        next_control[`ADC_CTL_CS_MSB:`ADC_CTL_CHS_LSB] = pwdata[`ADC_CTL_CS_MSB:`ADC_CTL_CHS_LSB];
      end
    end
    if (start)
      next_control[`ADC_CTL_GO] = 1'b1;
    if (finish || abort)
      next_control[`ADC_CTL_GO] = 1'b0;
  end

  // Successive approximation: each bit period decides one result bit.
  always_comb
  begin
    next_state = state;
    next_sar = sar;
    next_bit_index = bit_index;
    case (state)
      adc_seq_pkg::seq_idle:
      begin
        if (start)
        begin
          next_state = adc_seq_pkg::seq_convert;
          next_sar = `ADC_SAR_START;
          next_bit_index = `ADC_RESULT_MSB;
        end
      end
      adc_seq_pkg::seq_convert:
      begin
        if (abort)
          next_state = adc_seq_pkg::seq_idle;
        else if (tad_tick)
        begin
          next_sar = cmp_high ? sar : cmp_keep[7:0];
          if (bit_index == 3'h0)
            next_state = adc_seq_pkg::seq_idle;
          else
          begin
            next_sar[bit_index - 3'h1] = 1'b1;
            next_bit_index = bit_index - 3'h1;
          end
        end
      end
      default:
        next_state = adc_seq_pkg::seq_idle;
    endcase
  end

  // Final decision of the least significant bit goes straight to the result.
  wire [7:0] final_code = cmp_high ? sar : cmp_keep[7:0];

  // Hardware set wins over a write-one-to-clear in the same cycle.
  wire clear_done = wr && hit_status && pwdata[`ADC_DONE_BIT];
  assign next_done_flag = finish ? 1'b1 :
    (clear_done ? 1'b0 : conversion_done_flag);

  assign next_pin_config = (wr && hit_pin_config) ? pwdata[3:0] : pin_config;
  assign next_pin_direction_bits = (wr && hit_pin_dir) ? pwdata[3:0] : pin_direction_bits;

  // ----------------------------------------------------------------------
  // Read data, captured in the setup cycle
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_prdata = 32'h0000_0000;
    if (hit_control)
      next_prdata[7:0] = control;
    else if (hit_pin_config)
      next_prdata[3:0] = pin_config;
    else if (hit_result)
      next_prdata[7:0] = conversion_result_reg;
    else if (hit_status)
      next_prdata[`ADC_DONE_BIT] = conversion_done_flag;
    else if (hit_mask)
      next_prdata[`ADC_DONE_BIT] = conversion_irq_enable;
    else if (hit_global)
      next_prdata[0] = global_irq_enable;
    else if (hit_pin_dir)
      next_prdata[3:0] = pin_direction_bits;
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= adc_seq_pkg::seq_idle;
      control <= `ADC_CTL_RESET;
      sar <= 8'h00;
      bit_index <= 3'h0;
      conversion_done_flag <= 1'b0;
    end
    else
    begin
      state <= next_state;
      control <= next_control;
      sar <= next_sar;
      bit_index <= next_bit_index;
      conversion_done_flag <= next_done_flag;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      conversion_irq_enable <= 1'b0;
      global_irq_enable <= 1'b0;
      pin_config <= `ADC_PIN_CONFIG_RESET;
      pin_direction_bits <= `ADC_PIN_DIR_RESET;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      if (wr && hit_mask)
        conversion_irq_enable <= pwdata[`ADC_DONE_BIT];
      if (wr && hit_global)
        global_irq_enable <= pwdata[0];
      pin_config <= next_pin_config;
      pin_direction_bits <= next_pin_direction_bits;
      if (setup)
        prdata <= next_prdata;
    end
  end

  // The result register has no reset so it keeps its content across resets.
  always_ff @(posedge pclk)
  begin
    if (finish)
      conversion_result_reg <= final_code;
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign dac_code = sar;
  assign channel_sel = control[`ADC_CTL_CHS_MSB:`ADC_CTL_CHS_LSB];
  assign converter_power = conv_on;
  // Acquisition runs whenever the converter is on and idle.
  assign sample_hold = conv_on && !busy;
  assign irq = global_irq_enable && conversion_irq_enable && conversion_done_flag;

endmodule

// ===== tb/adc_seq_checker.sv
/*
  Port checks of the conversion sequencer.
  Assumes it is bound to adc_sequencer and that pclk runs throughout.
*/
`timescale 1ns/100ps
`include "adc_seq_map.svh"

module adc_seq_checker
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Converter and interrupt
  input wire logic [7:0] dac_code,
  input wire logic sample_hold,
  input wire logic converter_power,
  input wire logic [3:0] pin_config,
  input wire logic irq
);
  // ------------------------------------------------------------------
  // Decoded bus cycles
  // ------------------------------------------------------------------
  wire logic wr = psel && penable && pwrite;
  wire logic wr_ctl = wr && paddr == `ADC_OFS_CONTROL;
  wire logic start = wr_ctl && sample_hold && pwdata[0] && pwdata[2];
  wire logic mapped = paddr <= `ADC_OFS_PIN_DIR && paddr[1:0] == 2'b00;
  wire logic [3:0] low = pwdata[3:0];

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pready_high: assert property (psel |-> pready) else $error("pready low");
  a_slverr_map: assert property (psel && penable |-> pslverr == !mapped)
    else $error("pslverr does not match the address map");
  a_power_write: assert property (wr_ctl |=> converter_power == $past(low[0]))
    else $error("converter power not updated");
  a_pin_config: assert property (wr && paddr == `ADC_OFS_PIN_CONFIG |=>
    pin_config == $past(low)) else $error("pin config not updated");
  a_start_trial: assert property (start |=> dac_code == `ADC_SAR_START && !sample_hold)
    else $error("conversion did not start");
  a_conv_time: assert property (start && pwdata[7:6] == 2'b00 |->
    ##16 !sample_hold ##1 sample_hold) else $error("conversion length wrong");
  a_irq_global: assert property (wr && paddr == `ADC_OFS_GLOBAL_IRQ && !low[0] |=> !irq)
    else $error("irq high with global enable off");
  a_irq_clear: assert property (wr && paddr == `ADC_OFS_IRQ_STATUS && low[0] &&
    sample_hold |=> !irq) else $error("irq not cleared");
endmodule

bind adc_sequencer adc_seq_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .dac_code(dac_code), .sample_hold(sample_hold),
  .converter_power(converter_power), .pin_config(pin_config), .irq(irq));

// ===== tb/adc_conversion_sequencer_tb.sv
/*
  Self-checking bench of the conversion sequencer over APB.
  Assumes the register map header; the comparator is modelled here.
*/
`timescale 1ns/100ps
`include "adc_seq_map.svh"

module adc_conversion_sequencer_tb;
  logic pclk, presetn, psel, penable, pwrite, cmp_high, pready, pslverr, sample_hold;
  logic converter_power, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] dac_code, analog, res;
  logic [2:0] channel_sel, ch;
  logic [3:0] pin_config, pin_direction_bits, cfg;
  logic [32:0] notes[$];
  int mismatches, compares, cycles;
  // Acquisition time in clocks; a plain figure chosen for this bench.
  localparam int acq_cycles = 8;

  adc_sequencer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmp_high(cmp_high), .dac_code(dac_code), .channel_sel(channel_sel),
    .sample_hold(sample_hold), .converter_power(converter_power), .pin_config(pin_config),
    .pin_direction_bits(pin_direction_bits), .irq(irq));

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task results();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task compare(input logic [32:0] exp, input logic [32:0] got);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    notes.push_back(e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (!pready)
      @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask

  task rd(input logic [11:0] a, input logic [31:0] d);
    apb(1'b0, a, 32'h0, {1'b0, d});
  endtask

  task convert(input logic [1:0] cs, input logic en);
    int t0;
    int period;
    analog = 8'($urandom);
    ch = 3'($urandom);
    period = (cs == 2'h0) ? `ADC_TAD_DIV0 :
             (cs == 2'h1) ? `ADC_TAD_DIV1 :
             (cs == 2'h2) ? `ADC_TAD_DIV2 : `ADC_TAD_DIV3;
    wr(`ADC_OFS_CONTROL, {24'h0, cs, ch, 3'b001});
    repeat (acq_cycles) @(posedge pclk);
    wr(`ADC_OFS_CONTROL, {24'h0, cs, ch, 3'b101});
    t0 = cycles;
    rd(`ADC_OFS_CONTROL, {24'h0, cs, ch, 3'b101});
    while (!sample_hold)
      @(posedge pclk);
    // The idle level is seen one edge after the completing edge.
    compare(33'(cycles - t0), 33'(8 * period + 1));
    compare({30'h0, channel_sel}, {30'h0, ch});
    rd(`ADC_OFS_RESULT, {24'h0, analog});
    rd(`ADC_OFS_CONTROL, {24'h0, cs, ch, 3'b001});
    rd(`ADC_OFS_IRQ_STATUS, 32'h1);
    compare({32'h0, irq}, {32'h0, en});
    wr(`ADC_OFS_IRQ_STATUS, 32'h1);
    rd(`ADC_OFS_IRQ_STATUS, 32'h0);
    repeat (2 * `ADC_TAD_DIV3) @(posedge pclk);
  endtask

  // ------------------------------------------------------------------
  // Comparator model, result monitor and timeout
  // ------------------------------------------------------------------
  always @(posedge pclk)
  begin
    cmp_high <= analog >= dac_code;
    cycles <= cycles + 1;
    if (psel && penable && pready)
      compare(notes.pop_front(), {pslverr, pwrite ? 32'h0 : prdata});
    if (cycles > 5000)
    begin
      mismatches++;
      results();
    end
  end

  initial
  begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    analog = 8'h0;
    void'($urandom(32'hf449));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(`ADC_OFS_CONTROL, 32'h0);
    rd(`ADC_OFS_PIN_CONFIG, 32'h0);
    rd(`ADC_OFS_IRQ_STATUS, 32'h0);
    rd(`ADC_OFS_IRQ_MASK, 32'h0);
    rd(`ADC_OFS_GLOBAL_IRQ, 32'h0);
    rd(`ADC_OFS_PIN_DIR, 32'hf);
    apb(1'b0, 12'h01c, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 12'h020, 32'hffffffff, {1'b1, 32'h0});
    cfg = 4'($urandom);
    wr(`ADC_OFS_PIN_CONFIG, {28'h0, cfg});
    rd(`ADC_OFS_PIN_CONFIG, {28'h0, cfg});
    wr(`ADC_OFS_PIN_DIR, {28'h0, ~cfg});
    @(negedge pclk);
    compare({29'h0, pin_direction_bits}, {29'h0, ~cfg});
    wr(`ADC_OFS_IRQ_STATUS, 32'h1);
    wr(`ADC_OFS_IRQ_MASK, 32'h1);
    wr(`ADC_OFS_GLOBAL_IRQ, 32'h1);
    for (int i = 0; i < 4; i++)
      convert(2'(i), 1'b1);
    wr(`ADC_OFS_GLOBAL_IRQ, 32'h0);
    convert(2'b00, 1'b0);
    wr(`ADC_OFS_IRQ_MASK, 32'h0);
    wr(`ADC_OFS_GLOBAL_IRQ, 32'h1);
    convert(2'b00, 1'b0);
    res = analog;
    wr(`ADC_OFS_CONTROL, 32'hc5);
    repeat (20) @(posedge pclk);
    wr(`ADC_OFS_CONTROL, 32'h0);
    // Clock select stays frozen by the aborting write, only power and go drop.
    rd(`ADC_OFS_CONTROL, 32'hc0);
    rd(`ADC_OFS_IRQ_STATUS, 32'h0);
    rd(`ADC_OFS_RESULT, {24'h0, res});
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(`ADC_OFS_RESULT, {24'h0, res});
    results();
  end
endmodule
